// *** bench/tmw_timer_tb_top.sv ***
`timescale 1ns/1ps
module tmw_timer_tb_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] src = 3'h0;
    logic [1:0] md = 2'h0;
    logic [1:0] act = 2'h0;
    logic foc = 1'b0;
    logic cwr = 1'b0;
    logic [7:0] cwd = 8'h00;
    logic pwr = 1'b0;
    logic [7:0] pwd = 8'h00;
    logic ovc = 1'b0;
    logic mtc = 1'b0;
    logic dir = 1'b0;
    logic pd = 1'b1;
    logic [7:0] cnt, cmp, mx, hold;
    logic ovf, mf, oc, pin, oe_n;
    int error_cnt = 0;
    int n_tests = 0;
    int hi, edg;

    tmw_timer tmw_timer_inst (
        .sys_clk(sys_clk), .rstn(rstn),
        .clock_source_select(src), .waveform_mode_select(md),
        .output_action_select(act), .force_match_strobe(foc),
        .counter_wr(cwr), .counter_wdata(cwd),
        .compare_wr(pwr), .compare_wdata(pwd),
        .overflow_clr(ovc), .match_clr(mtc),
        .pin_dir_out(dir), .port_data(pd),
        .counter_value(cnt), .compare_value(cmp),
        .overflow_flag(ovf), .match_flag(mf), .compare_output(oc),
        .pin_out(pin), .pin_oe_n(oe_n)
    );

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic setc(input logic [2:0] s, input logic [1:0] m,
                        input logic [1:0] a);
        @(posedge sys_clk);
        src <= s;
        md <= m;
        act <= a;
    endtask

    // Pulse writes last exactly one cycle
    task automatic wr_cnt(input logic [7:0] v);
        @(posedge sys_clk);
        cwr <= 1'b1;
        cwd <= v;
        @(posedge sys_clk);
        cwr <= 1'b0;
    endtask

    task automatic wr_cmp(input logic [7:0] v);
        @(posedge sys_clk);
        pwr <= 1'b1;
        pwd <= v;
        @(posedge sys_clk);
        pwr <= 1'b0;
    endtask

    task automatic clr();
        @(posedge sys_clk);
        ovc <= 1'b1;
        mtc <= 1'b1;
        @(posedge sys_clk);
        ovc <= 1'b0;
        mtc <= 1'b0;
    endtask

    task automatic frc();
        @(posedge sys_clk);
        foc <= 1'b1;
        @(posedge sys_clk);
        foc <= 1'b0;
    endtask

    // Bounded: a counter stuck short of v ends the run
    task automatic wait_cnt(input logic [7:0] v);
        for (int i = 0; i < 600; i++) begin
            @(negedge sys_clk);
            if (cnt === v) return;
        end
        error_cnt++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, cnt, v);
        test_done();
    endtask

    // Any window of whole periods gives a phase-free count
    task automatic measure(input int n);
        logic p;
        p = oc;
        hi = 0;
        edg = 0;
        mx = 8'h00;
        repeat (n) begin
            @(negedge sys_clk);
            if (oc === 1'b1) hi++;
            if (oc !== p) edg++;
            if (cnt > mx) mx = cnt;
            p = oc;
        end
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        cyc(1);
        chk(cnt, 16'h0000);
        chk(cmp, 16'h0000);
        chk(oc, 16'h0000);
        chk(oe_n, 16'h0001);
        $display("reset test done");
        wr_cmp(8'h80);
        wr_cnt(8'hfe);
        setc(3'h1, 2'h0, 2'h0);
        wait_cnt(8'hff);
        cyc(1);
        chk(cnt, 16'h0000);
        cyc(2);
        chk(ovf, 16'h0001);
        wait_cnt(8'h81);
        cyc(1);
        chk(mf, 16'h0001);
        setc(3'h0, 2'h0, 2'h0);
        cyc(2);
        hold = cnt;
        cyc(5);
        chk(cnt, hold);
        wr_cnt(8'h33);
        cyc(1);
        chk(cnt, 16'h0033);
        clr();
        wr_cmp(8'h40);
        wr_cnt(8'h40);
        setc(3'h1, 2'h0, 2'h0);
        cyc(6);
        chk(mf, 16'h0000);
        chk(oc, 16'h0000);
        $display("normal mode test done");
        setc(3'h0, 2'h0, 2'h3);
        frc();
        cyc(2);
        chk(oc, 16'h0001);
        setc(3'h0, 2'h0, 2'h0);
        frc();
        cyc(2);
        chk(oc, 16'h0001);
        setc(3'h0, 2'h2, 2'h2);
        cyc(3);
        chk(oc, 16'h0001);
        frc();
        cyc(2);
        chk(oc, 16'h0000);
        setc(3'h0, 2'h3, 2'h3);
        frc();
        cyc(2);
        chk(oc, 16'h0000);
        setc(3'h0, 2'h1, 2'h1);
        frc();
        cyc(2);
        chk(oc, 16'h0000);
        $display("force test done");
        // Compare writes go straight through only outside fast PWM
        clr();
        setc(3'h0, 2'h2, 2'h1);
        wr_cnt(8'h00);
        wr_cmp(8'h05);
        @(posedge sys_clk);
        dir <= 1'b1;
        setc(3'h1, 2'h2, 2'h1);
        cyc(4);
        measure(60);
        chk(edg, 16'h000a);
        chk(mx, 16'h0005);
        chk(mf, 16'h0001);
        chk(ovf, 16'h0000);
        setc(3'h0, 2'h2, 2'h3);
        frc();
        cyc(2);
        chk(pin, 16'h0001);
        chk(oe_n, 16'h0000);
        setc(3'h0, 2'h2, 2'h0);
        pd <= 1'b0;
        cyc(2);
        chk(pin, 16'h0000);
        wr_cnt(8'h10);
        wr_cmp(8'h05);
        setc(3'h1, 2'h2, 2'h1);
        wait_cnt(8'hff);
        cyc(1);
        chk(cnt, 16'h0000);
        cyc(2);
        chk(ovf, 16'h0001);
        $display("clear on match test done");
        setc(3'h0, 2'h3, 2'h2);
        wr_cmp(8'h40);
        setc(3'h1, 2'h3, 2'h2);
        wait_cnt(8'hff);
        wait_cnt(8'h01);
        measure(256);
        chk(hi, 16'h0041);
        chk(mx, 16'h00ff);
        chk(edg, 16'h0002);
        clr();
        wait_cnt(8'h00);
        cyc(2);
        chk(ovf, 16'h0001);
        wait_cnt(8'h10);
        wr_cmp(8'hff);
        cyc(2);
        chk(cmp, 16'h0040);
        wait_cnt(8'hff);
        wait_cnt(8'h01);
        chk(cmp, 16'h00ff);
        measure(256);
        chk(hi, 16'h0100);
        wr_cmp(8'h00);
        wait_cnt(8'hff);
        wait_cnt(8'h01);
        measure(256);
        chk(hi, 16'h0001);
        wr_cmp(8'h40);
        setc(3'h1, 2'h3, 2'h3);
        wait_cnt(8'hff);
        wait_cnt(8'h01);
        measure(256);
        chk(hi, 16'h00bf);
        setc(3'h1, 2'h3, 2'h1);
        wait_cnt(8'hff);
        measure(512);
        chk(edg, 16'h0002);
        chk(mx, 16'h00ff);
        $display("fast pwm test done");
        setc(3'h0, 2'h0, 2'h0);
        wr_cnt(8'h00);
        setc(3'h2, 2'h0, 2'h0);
        cyc(4);
        hold = cnt;
        cyc(64);
        chk(8'(cnt - hold), 16'h0008);
        setc(3'h5, 2'h0, 2'h0);
        cyc(4);
        hold = cnt;
        cyc(1024);
        chk(8'(cnt - hold), 16'h0001);
        setc(3'h6, 2'h0, 2'h0);
        cyc(4);
        hold = cnt;
        cyc(64);
        chk(cnt, hold);
        $display("prescale test done");
        test_done();
    end
endmodule

// *** common/tmw_pkg.sv ***
package tmw_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] OCR_RESET = 8'h00;
    localparam logic OC_RESET = 1'b0;
    // Waveform mode select codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PHASE = 2'h1;
    localparam logic [1:0] MODE_CLEAR = 2'h2;
    localparam logic [1:0] MODE_FAST = 2'h3;
    // Output action select codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // Clock source select codes and prescale masks (divide minus one)
    localparam int PRE_W = 10;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] MASK_DIV1 = 10'h000;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03f;
    localparam logic [9:0] MASK_DIV256 = 10'h0ff;
    localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
    localparam logic [9:0] PRE_RESET = 10'h000;
endpackage

// *** common/tmw_tick_if.sv ***
`timescale 1ns/1ps
interface tmw_tick_if;
    logic [2:0] sel;
    logic tick;
    modport src (input sel, output tick);
    modport dst (output sel, input tick);
endinterface

// *** rtl/tmw_prescaler.sv ***
`timescale 1ns/1ps
module tmw_prescaler (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Tick link
    tmw_tick_if.src tk
);
    logic [tmw_pkg::PRE_W-1:0] pre_q;
    logic [tmw_pkg::PRE_W-1:0] mask;
    logic run;

    always_comb begin
        run = 1'b1;
        mask = tmw_pkg::MASK_DIV1;
        if (tk.sel == tmw_pkg::CS_DIV1) begin
            mask = tmw_pkg::MASK_DIV1;
        end else if (tk.sel == tmw_pkg::CS_DIV8) begin
            mask = tmw_pkg::MASK_DIV8;
        end else if (tk.sel == tmw_pkg::CS_DIV64) begin
            mask = tmw_pkg::MASK_DIV64;
        end else if (tk.sel == tmw_pkg::CS_DIV256) begin
            mask = tmw_pkg::MASK_DIV256;
        end else if (tk.sel == tmw_pkg::CS_DIV1024) begin
            mask = tmw_pkg::MASK_DIV1024;
        end else begin
            // Stopped, and the external sources are not built
            run = 1'b0;
        end
    end

    // Free-running divider shared by all ratios
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= tmw_pkg::PRE_RESET;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tk.tick <= 1'b0;
        end else begin
            tk.tick <= run && ((pre_q & mask) == mask);
        end
    end
endmodule

// *** rtl/tmw_timer.sv ***
`timescale 1ns/1ps
// Behaviour
// - Action zero leaves compare output unchanged
// - New action applies at next match
// - Force strobe applies action now, non-PWM
// - Count depends on mode, not action
// - Normal mode increments, wraps ff to 00
// - Normal overflow flag set when count wraps
// - Counter writable any time in normal
// - Clear-on-match mode clears at compare value
// - Match flag raised each top reach
// - Clear-on-match compare value written directly
// - Action one toggles output on match
// - Pin driven only when direction is output
// - Clear-on-match overflow set passing max
// - Fast PWM counts zero up to max
// - Fast PWM clears after max
// - Fast PWM action 2/3 polarity at match/wrap
// - Fast PWM overflow set at max
// - Zero gives spike, max gives constant
// - Fast PWM action one toggles on match
// - Fast PWM compare value double buffered
// - Fast PWM period is 256 ticks
// - Timer tick is prescaled clock
// - Source zero stops counting, access remains
// - Match flag set on following tick
// - Counter write blocks next tick match
module tmw_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control
    input wire logic [2:0] clock_source_select,
    input wire logic [1:0] waveform_mode_select,
    input wire logic [1:0] output_action_select,
    input wire logic force_match_strobe,
    // Counter and compare writes
    input wire logic counter_wr,
    input wire logic [7:0] counter_wdata,
    input wire logic compare_wr,
    input wire logic [7:0] compare_wdata,
    // Flag clears
    input wire logic overflow_clr,
    input wire logic match_clr,
    // Port pin
    input wire logic pin_dir_out,
    input wire logic port_data,
    // Status
    output logic [7:0] counter_value,
    output logic [7:0] compare_value,
    output logic overflow_flag,
    output logic match_flag,
    output logic compare_output,
    // Pin drive
    output logic pin_out,
    output logic pin_oe_n
);
    tmw_tick_if tk ();

    logic tick;
    logic [7:0] cnt_q;
    logic [7:0] ocr_q;
    logic [7:0] ocr_buf_q;
    logic block_q;
    logic ovf_q;
    logic mf_q;
    logic oc_q;
    logic pin_q;
    logic oe_n_q;
    logic fast;
    logic at_max;
    logic at_top;
    logic eq;
    logic match;
    logic apply;

    assign tk.sel = clock_source_select;
    assign tick = tk.tick;

    tmw_prescaler u_pre (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tk(tk)
    );

    assign fast = (waveform_mode_select == tmw_pkg::MODE_FAST);
    assign at_max = (cnt_q == tmw_pkg::CNT_MAX);
    assign eq = (cnt_q == ocr_q);
    // Top follows the mode only; the action never enters here
    assign at_top = (waveform_mode_select == tmw_pkg::MODE_CLEAR) ?
        eq : at_max;
    // A write in this cycle also blocks, as the tick would see old count
    assign match = tick && eq && !block_q && !counter_wr;
    // Force acts only outside the PWM modes and ignores the flags
    assign apply = match || (force_match_strobe &&
        !waveform_mode_select[0]);

    // Counter: a write has priority over clear and count
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= tmw_pkg::CNT_RESET;
        end else if (counter_wr) begin
            cnt_q <= counter_wdata;
        end else if (tick) begin
            // A blocked match must not clear, or the write would be lost
            if (at_top && !block_q &&
                waveform_mode_select == tmw_pkg::MODE_CLEAR) begin
                cnt_q <= tmw_pkg::CNT_BOTTOM;
            end else begin
                // Wraps ff to 00 in normal and fast PWM
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // Match blocking after a counter write, held until a tick eats it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            block_q <= 1'b0;
        end else if (counter_wr) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // Compare value: direct outside fast PWM, buffered to bottom in fast PWM
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ocr_buf_q <= tmw_pkg::OCR_RESET;
        end else if (compare_wr) begin
            ocr_buf_q <= compare_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ocr_q <= tmw_pkg::OCR_RESET;
        end else if (fast) begin
            if (tick && at_max && !counter_wr) begin
                ocr_q <= ocr_buf_q;
            end
        end else if (compare_wr) begin
            // A value below the count is missed until the wrap
            ocr_q <= compare_wdata;
        end
    end

    // Overflow flag: set at the max to bottom step, set wins over clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ovf_q <= 1'b0;
        end else if (tick && at_max && !counter_wr) begin
            ovf_q <= 1'b1;
        end else if (overflow_clr) begin
            ovf_q <= 1'b0;
        end
    end

    // Match flag: set on the tick that ends the equal cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mf_q <= 1'b0;
        end else if (match) begin
            mf_q <= 1'b1;
        end else if (match_clr) begin
            mf_q <= 1'b0;
        end
    end

    // Compare output state; action is read live so a change
    // only shows at the next match or force strobe, or at the wrap in fast PWM
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            oc_q <= tmw_pkg::OC_RESET;
        end else if (fast) begin
            // Bottom wins over match so a max compare stays constant
            if (tick && at_max && !counter_wr &&
                output_action_select[1]) begin
                oc_q <= !output_action_select[0];
            end else if (match) begin
                case (output_action_select)
                    tmw_pkg::ACT_TOGGLE: begin
                        oc_q <= !oc_q;
                    end
                    tmw_pkg::ACT_CLEAR: begin
                        oc_q <= 1'b0;
                    end
                    tmw_pkg::ACT_SET: begin
                        oc_q <= 1'b1;
                    end
                    default: begin
                        oc_q <= oc_q;
                    end
                endcase
            end
        end else if (!waveform_mode_select[0] && apply) begin
            case (output_action_select)
                tmw_pkg::ACT_TOGGLE: begin
                    oc_q <= !oc_q;
                end
                tmw_pkg::ACT_CLEAR: begin
                    oc_q <= 1'b0;
                end
                tmw_pkg::ACT_SET: begin
                    oc_q <= 1'b1;
                end
                default: begin
                    oc_q <= oc_q;
                end
            endcase
        end
    end

    // Pin: compare output overrides port data, direction gates drive
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            pin_q <= (output_action_select != tmw_pkg::ACT_NONE) ?
                oc_q : port_data;
            oe_n_q <= !pin_dir_out;
        end
    end

    assign counter_value = cnt_q;
    assign compare_value = ocr_q;
    assign overflow_flag = ovf_q;
    assign match_flag = mf_q;
    assign compare_output = oc_q;
    assign pin_out = pin_q;
    assign pin_oe_n = oe_n_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence wrap_step;
        tick && at_max && !counter_wr;
    endsequence

    sequence clean_match;
        tick && eq && !block_q && !counter_wr;
    endsequence

    sequence stopped_two;
        (clock_source_select == tmw_pkg::CS_STOP)[*2];
    endsequence

    no_action_hold_a: assert property (
        output_action_select == tmw_pkg::ACT_NONE |=> $stable(oc_q))
        else $error("Output changed with action zero");

    force_toggle_a: assert property (
        force_match_strobe && !waveform_mode_select[0] &&
        output_action_select == tmw_pkg::ACT_TOGGLE |=>
        oc_q != $past(oc_q))
        else $error("Force strobe did not toggle output");

    normal_wrap_a: assert property (
        wrap_step ##0 (waveform_mode_select == tmw_pkg::MODE_NORMAL) |=>
        cnt_q == tmw_pkg::CNT_BOTTOM && ovf_q)
        else $error("Normal wrap or overflow flag wrong");

    overflow_set_a: assert property (
        wrap_step |=> ovf_q ##1 (ovf_q || $past(overflow_clr)))
        else $error("Overflow flag not set at wrap");

    clear_top_a: assert property (
        tick && eq && !counter_wr && !block_q &&
        waveform_mode_select == tmw_pkg::MODE_CLEAR |=>
        cnt_q == tmw_pkg::CNT_BOTTOM)
        else $error("Clear-on-match did not clear");

    match_flag_a: assert property (
        clean_match |=> mf_q)
        else $error("Match flag not set after match");

    write_block_a: assert property (
        counter_wr ##1 (tick && !mf_q && !match_clr &&
        !counter_wr) |=> !mf_q)
        else $error("Match not blocked after counter write");

    stop_count_a: assert property (
        stopped_two ##0 !counter_wr |=> $stable(cnt_q))
        else $error("Counter moved while stopped");

    fast_polarity_a: assert property (
        wrap_step ##0 fast &&
        output_action_select == tmw_pkg::ACT_CLEAR |=> oc_q)
        else $error("Non-inverted output not set at wrap");

    fast_buffer_a: assert property (
        fast && !(tick && at_max) |=> $stable(ocr_q))
        else $error("Fast PWM compare updated off bottom");

    pin_dir_a: assert property (
        !pin_dir_out |=> pin_oe_n)
        else $error("Pin driven while direction is input");

    write_wins_a: assert property (
        counter_wr |=> cnt_q == $past(counter_wdata))
        else $error("Counter write not taken");

    count_step_a: assert property (
        tick && !counter_wr &&
        waveform_mode_select != tmw_pkg::MODE_CLEAR |=>
        cnt_q == $past(cnt_q) + 8'h01)
        else $error("Counter did not step by one");

    fast_restart_a: assert property (
        wrap_step ##0 fast |=> cnt_q == tmw_pkg::CNT_BOTTOM && ovf_q)
        else $error("Fast PWM did not restart at bottom");

    ctc_flag_a: assert property (
        clean_match ##0 waveform_mode_select == tmw_pkg::MODE_CLEAR |=>
        mf_q && cnt_q == tmw_pkg::CNT_BOTTOM)
        else $error("Clear-on-match flag or clear missing");

    ctc_toggle_a: assert property (
        clean_match ##0 (waveform_mode_select == tmw_pkg::MODE_CLEAR &&
        output_action_select == tmw_pkg::ACT_TOGGLE) |=>
        oc_q != $past(oc_q))
        else $error("Clear-on-match toggle missing");

    fast_inverted_a: assert property (
        wrap_step ##0 fast &&
        output_action_select == tmw_pkg::ACT_SET |=> !oc_q)
        else $error("Inverted output not cleared at wrap");

    fast_match_clear_a: assert property (
        clean_match ##0 fast && !at_max &&
        output_action_select == tmw_pkg::ACT_CLEAR |=> !oc_q)
        else $error("Non-inverted output not cleared at match");

    fast_toggle_a: assert property (
        clean_match ##0 fast &&
        output_action_select == tmw_pkg::ACT_TOGGLE |=>
        oc_q != $past(oc_q))
        else $error("Fast PWM toggle missing");

    tick_full_a: assert property (
        (clock_source_select == tmw_pkg::CS_DIV1)[*2] |-> tick)
        else $error("Undivided tick missing");
endmodule
